// [shared/ppm_regs.svh]
`ifndef PPM_REGS_SVH
`define PPM_REGS_SVH

// clock and time base
`define PPM_CLK_MHZ        200
`define PPM_TICK_NS        1000
`define PPM_TICK_CYCLES    (`PPM_TICK_NS * `PPM_CLK_MHZ / 1000)
`define PPM_TICK_W         8

// supply-failure response
`define PPM_HALT_LIMIT     10
`define PPM_REDUCE_MS      5
`define PPM_BUDGET_W       20
`define PPM_BUDGET_MARGIN  4

// frequency synthesizer
`define PPM_FREQ_W         16
`define PPM_STEP_MHZ       16'h0019
`define PPM_FREQ_RESET     16'h0000

// cores and voltage
`define PPM_NCORES         12
`define PPM_VID_W          8
`define PPM_VID_RESET      8'h00

`endif

// [shared/ppm_pkg.sv]
`include "ppm_regs.svh"

package ppm_pkg;

  typedef logic [`PPM_FREQ_W-1:0] freq_t;
  typedef logic [`PPM_VID_W-1:0]  vid_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_RAMP,
    ST_REDUCED
  } pm_state_t;

endpackage

// [core/freq_ramp.sv]
`include "ppm_regs.svh"

module freq_ramp
  import ppm_pkg::*;
(
  input  wire logic  clock_in,
  input  wire logic  rst_in,
  input  wire logic  tick_in,
  input  wire freq_t target_in,
  output freq_t      freq_out
);

  freq_t next_freq;

  // one fixed step per microsecond tick, last step lands exactly on target
  always_comb begin
    next_freq = freq_out;
    if (tick_in) begin
      if (freq_out > target_in) begin
        if ((freq_out - target_in) > `PPM_STEP_MHZ) begin
          next_freq = freq_out - `PPM_STEP_MHZ;
        end else begin
          next_freq = target_in;
        end
      end else if (freq_out < target_in) begin
        if ((target_in - freq_out) > `PPM_STEP_MHZ) begin
          next_freq = freq_out + `PPM_STEP_MHZ;
        end else begin
          next_freq = target_in;
        end
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      freq_out <= `PPM_FREQ_RESET;
    end else begin
      freq_out <= next_freq;
    end
  end

endmodule // freq_ramp

// [core/core_power_ctl.sv]
`include "ppm_regs.svh"

module core_power_ctl
  import ppm_pkg::*;
#(
  parameter int unsigned REDUCE_LIMIT_CYCLES = `PPM_REDUCE_MS * 1000 * `PPM_CLK_MHZ
)(
  input  wire logic                      clock_in,
  input  wire logic                      rst_in,
  input  wire logic                      supply_fail_in,
  input  wire logic [`PPM_NCORES-1:0]    core_idle_in,
  input  wire logic [`PPM_NCORES-1:0]    core_l3_gate_in,
  input  wire logic [`PPM_NCORES-1:0]    core_deconfig_in,
  input  wire vid_t [`PPM_NCORES-1:0]    core_vid_in,
  input  wire freq_t                     nominal_freq_in,
  input  wire freq_t                     floor_freq_in,
  output logic                           fetch_halt_out,
  output logic                           power_reduced_out,
  output freq_t                          freq_request_out,
  output logic [`PPM_NCORES-1:0]         core_gate_out,
  output logic [`PPM_NCORES-1:0]         cache_gate_out,
  output vid_t                           core_rail_vid_out
);

  localparam logic [`PPM_TICK_W-1:0]   TICK_LAST   = `PPM_TICK_W'(`PPM_TICK_CYCLES - 1);
  localparam logic [`PPM_BUDGET_W-1:0] BUDGET_LAST = `PPM_BUDGET_W'(REDUCE_LIMIT_CYCLES - `PPM_BUDGET_MARGIN);
  localparam int                       HALT_LIMIT  = `PPM_HALT_LIMIT;

  function automatic vid_t max_vid(input vid_t [`PPM_NCORES-1:0] v, input logic [`PPM_NCORES-1:0] skip);
    vid_t m;
    m = `PPM_VID_RESET;
    for (int i = 0; i < `PPM_NCORES; i++) begin
      if (!skip[i] && v[i] > m) begin
        m = v[i];
      end
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // microsecond tick

  logic [`PPM_TICK_W-1:0] tick_count;
  logic [`PPM_TICK_W-1:0] next_tick_count;
  logic                   us_tick;
  logic                   next_us_tick;

  always_comb begin
    next_us_tick    = (tick_count == TICK_LAST);
    next_tick_count = next_us_tick ? '0 : tick_count + `PPM_TICK_W'(1);
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      tick_count <= '0;
      us_tick    <= 1'b0;
    end else begin
      tick_count <= next_tick_count;
      us_tick    <= next_us_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // supply-failure response

  pm_state_t               state;
  pm_state_t               next_state;
  logic                    next_halt;
  logic                    next_reduced;
  logic [`PPM_BUDGET_W-1:0] age;
  logic [`PPM_BUDGET_W-1:0] next_age;
  freq_t                   ramp_target;

  always_comb begin
    next_state   = state;
    next_halt    = fetch_halt_out;
    next_reduced = power_reduced_out;
    next_age     = age;
    case (state)
      ST_RUN: begin
        next_age     = '0;
        next_reduced = 1'b0;
        next_halt    = 1'b0;
        if (supply_fail_in) begin
          next_state = ST_RAMP;
          next_halt  = 1'b1;
        end
      end
      ST_RAMP: begin
        next_age = age + `PPM_BUDGET_W'(1);
        if (!supply_fail_in) begin
          next_state = ST_RUN;
          next_halt  = 1'b0;
        end else if (freq_request_out <= floor_freq_in || age >= BUDGET_LAST) begin
          // deadline wins even if the ramp floor is set too low to reach in time
          next_state   = ST_REDUCED;
          next_reduced = 1'b1;
        end
      end
      ST_REDUCED: begin
        if (!supply_fail_in) begin
          next_state   = ST_RUN;
          next_halt    = 1'b0;
          next_reduced = 1'b0;
        end
      end
      default: begin
        next_state   = ST_RUN;
        next_halt    = 1'b0;
        next_reduced = 1'b0;
        next_age     = '0;
      end
    endcase
    // recovery climbs back at the same rate, so no current surge on release
    ramp_target = (state == ST_RUN && !supply_fail_in) ? nominal_freq_in : floor_freq_in;
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state             <= ST_RUN;
      fetch_halt_out    <= 1'b0;
      power_reduced_out <= 1'b0;
      age               <= '0;
    end else begin
      state             <= next_state;
      fetch_halt_out    <= next_halt;
      power_reduced_out <= next_reduced;
      age               <= next_age;
    end
  end

  freq_ramp u_ramp (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .tick_in   (us_tick),
    .target_in (ramp_target),
    .freq_out  (freq_request_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // power gating and shared core rail

  logic [`PPM_NCORES-1:0] next_core_gate;
  logic [`PPM_NCORES-1:0] next_cache_gate;
  vid_t                   next_rail_vid;

  always_comb begin
    next_core_gate  = core_deconfig_in | core_idle_in;
    next_cache_gate = next_core_gate & core_l3_gate_in;
    // deconfigured cores are gated, so their demand must not hold the rail up
    next_rail_vid   = max_vid(core_vid_in, core_deconfig_in);
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      core_gate_out     <= '1;
      cache_gate_out    <= '0;
      core_rail_vid_out <= `PPM_VID_RESET;
    end else begin
      core_gate_out     <= next_core_gate;
      cache_gate_out    <= next_cache_gate;
      core_rail_vid_out <= next_rail_vid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  logic [`PPM_BUDGET_W-1:0] fail_age;
  logic [`PPM_BUDGET_W-1:0] next_fail_age;

  // saturates so a long outage never wraps back under the deadline
  always_comb begin
    next_fail_age = fail_age;
    if (!supply_fail_in) begin
      next_fail_age = '0;
    end else if (!(&fail_age)) begin
      next_fail_age = fail_age + `PPM_BUDGET_W'(1);
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      fail_age <= '0;
    end else begin
      fail_age <= next_fail_age;
    end
  end

  sequence fail_rise_s;
    !fetch_halt_out && $rose(supply_fail_in);
  endsequence

  sequence halt_seen_s;
    ##[1:HALT_LIMIT] fetch_halt_out;
  endsequence

  halt_on_fail_a: assert property (fail_rise_s |-> halt_seen_s)
    else $error("fetch halt late after supply failure");

  halt_hold_a: assert property (supply_fail_in && fetch_halt_out |=> fetch_halt_out)
    else $error("fetch halt dropped while failure present");

  freq_tick_a: assert property ($changed(freq_request_out) |-> $past(us_tick))
    else $error("frequency changed off the microsecond tick");

  freq_step_a: assert property ($changed(freq_request_out) |->
      ((freq_request_out > $past(freq_request_out)) ?
       (freq_request_out - $past(freq_request_out) <= `PPM_STEP_MHZ) :
       ($past(freq_request_out) - freq_request_out <= `PPM_STEP_MHZ)))
    else $error("frequency step larger than one ramp step");

  reduce_deadline_a: assert property (supply_fail_in &&
      fail_age >= `PPM_BUDGET_W'(REDUCE_LIMIT_CYCLES - 1) |-> power_reduced_out)
    else $error("power not reduced within deadline");

  deconfig_gated_a: assert property (##1 (($past(core_deconfig_in) & ~core_gate_out) == '0))
    else $error("deconfigured core header not gated");

  // cache region only ever gated together with its core
  cache_with_core_a: assert property (##1 (((cache_gate_out & ~core_gate_out) == '0) &&
      (cache_gate_out == ($past(core_deconfig_in | core_idle_in) & $past(core_l3_gate_in)))))
    else $error("cache gate not matching idle gating mode");

  rail_max_a: assert property (##1 (core_rail_vid_out ==
      max_vid($past(core_vid_in), $past(core_deconfig_in))))
    else $error("core rail not at highest demand");

endmodule // core_power_ctl

// [dv/board_seq_model.sv]
module board_seq_model (
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  input  wire logic       fail_cmd_in,
  input  wire logic       pg_stuck_in,
  output logic [8:0]      rail_en_out,
  output logic            standby_reset_n_out,
  output logic            supply_fail_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // up order: standby 1v1, standby 3v3 a+b, pump, nest, pll, io, core, cache, dram supply+termination
  logic [8:0] rail_power_good;
  logic [7:0] dwell;
  logic [7:0] pg_wait;
  logic       fault;
  ////////////////////////////////////////
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rail_en_out <= '0;
      rail_power_good <= '0;
      dwell <= '0;
      pg_wait <= '0;
      fault <= 1'b0;
    end else begin
      // a stuck regulator holds every power good low
      rail_power_good <= rail_en_out & ~{9{pg_stuck_in}};
      if (fault) begin
        // newest rail first, so nest drops after pll, io, core and cache
        rail_en_out <= {1'b0, rail_en_out[8:1]};
      end else if (rail_en_out != rail_power_good) begin
        dwell <= '0;
        pg_wait <= pg_wait + 8'h01;
        fault <= (pg_wait == 8'h28);
      end else begin
        pg_wait <= '0;
        if (dwell < 8'h14) begin
          dwell <= dwell + 8'h01;
        end else if (!rail_en_out[8]) begin
          rail_en_out <= {rail_en_out[7:0], 1'b1};
        end
      end
    end
  end
  // failure only reported once the board is fully up
  assign standby_reset_n_out = rail_power_good[8] & ~fault;
  assign supply_fail_out = fail_cmd_in & rail_power_good[8];
endmodule // board_seq_model

// [dv/tb.sv]
`include "ppm_regs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module tb import ppm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 2000;
  logic        clock_in, rst_in, fail_cmd, halt, reduced, supply_fail;
  logic        standby_n, stuck;
  logic [8:0]  rail_en;
  logic [11:0] idle, l3, deconfig, core_gate, cache_gate;
  vid_t [11:0] vid;
  vid_t        rail_vid;
  freq_t       nominal, floor_f, freq;
  int          n_errors, n_compared;
  ////////////////////////////////////////
  board_seq_model partner (.clock_in(clock_in), .rst_in(rst_in), .fail_cmd_in(fail_cmd), .pg_stuck_in(stuck),
    .rail_en_out(rail_en), .standby_reset_n_out(standby_n), .supply_fail_out(supply_fail));
  core_power_ctl #(.REDUCE_LIMIT_CYCLES(LIMIT)) uut (.clock_in(clock_in), .rst_in(rst_in),
    .supply_fail_in(supply_fail), .core_idle_in(idle), .core_l3_gate_in(l3), .core_deconfig_in(deconfig),
    .core_vid_in(vid), .nominal_freq_in(nominal), .floor_freq_in(floor_f), .fetch_halt_out(halt),
    .power_reduced_out(reduced), .freq_request_out(freq), .core_gate_out(core_gate),
    .cache_gate_out(cache_gate), .core_rail_vid_out(rail_vid));
  ////////////////////////////////////////
  task automatic report_and_stop();
    $display("compared=%0d errors=%0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  // waits for ramp to settle, checking every step size on the way
  task automatic ramp_to(freq_t tgt);
    freq_t prev;
    int k;
    k = 0;
    prev = freq;
    while (freq !== tgt && k < 9000) begin
      cyc(1);
      k++;
      if (freq !== prev) begin
        `CHK((freq > prev) ? freq - prev : prev - freq, `PPM_STEP_MHZ)
      end
      prev = freq;
    end
    `CHK(freq, tgt)
  endtask
  ////////////////////////////////////////
  task automatic t_gate();
    @(posedge clock_in);
    idle <= 12'h4F0;
    l3 <= 12'h0A5;
    deconfig <= 12'h801;
    for (int i = 0; i < 12; i++) begin
      vid[i] <= 8'(i * 16);
    end
    cyc(2);
    `CHK(core_gate, 12'hCF1)
    `CHK(cache_gate, 12'hCF1 & 12'h0A5)
    `CHK(rail_vid, 8'hA0)
    @(posedge clock_in);
    deconfig <= 12'hFFF;
    cyc(2);
    `CHK(rail_vid, 8'h00)
    `CHK(core_gate, 12'hFFF)
    @(posedge clock_in);
    deconfig <= 12'h000;
    idle <= 12'h000;
    cyc(2);
    `CHK(core_gate, 12'h000)
    `CHK(rail_vid, 8'hB0)
    $display("test gate done");
  endtask
  // deadline case: floor far below, so only the age limit can end it
  task automatic t_fail(freq_t nom, freq_t flo, bit by_deadline);
    int k;
    @(posedge clock_in);
    nominal <= nom;
    floor_f <= flo;
    cyc(1);
    ramp_to(nom);
    `CHK(standby_n, 1'b1)
    @(posedge clock_in);
    fail_cmd <= 1'b1;
    k = 0;
    while (halt !== 1'b1 && k < 20) begin
      cyc(1);
      k++;
    end
    `CHK(k <= `PPM_HALT_LIMIT + 1, 1'b1)
    while (reduced !== 1'b1 && k < LIMIT + 8) begin
      cyc(1);
      k++;
    end
    `CHK(k <= LIMIT, 1'b1)
    `CHK(halt, 1'b1)
    if (by_deadline) begin
      `CHK(k >= LIMIT - 8, 1'b1)
    end else begin
      `CHK(freq, flo)
    end
    @(posedge clock_in);
    fail_cmd <= 1'b0;
    cyc(3);
    `CHK({halt, reduced}, 2'b00)
    $display("test fail done");
  endtask
  // stuck power good: board gives up and drops rails newest first
  task automatic t_board_fault();
    int k;
    @(posedge clock_in);
    stuck <= 1'b1;
    k = 0;
    while (rail_en !== 9'h000 && k < 200) begin
      cyc(1);
      k++;
      `CHK(standby_n, 1'b0)
      `CHK(rail_en & (rail_en + 9'h001), 9'h000)
    end
    `CHK(rail_en, 9'h000)
    $display("test board fault done");
  endtask
  ////////////////////////////////////////
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  // longest path is the deadline ramp, about 9000 cycles
  initial begin
    repeat (40000) @(posedge clock_in);
    n_errors++;
    report_and_stop();
  end
  initial begin
    n_errors = 0;
    n_compared = 0;
    rst_in = 1'b1;
    fail_cmd = 1'b0;
    stuck = 1'b0;
    idle = '0;
    l3 = '0;
    deconfig = '0;
    vid = '0;
    nominal = 16'h0064;
    floor_f = 16'h0032;
    cyc(20);
    `CHK({halt, reduced, freq, core_gate, cache_gate, rail_vid}, {2'b00, 16'h0000, 12'hFFF, 12'h000, 8'h00})
    @(posedge clock_in);
    rst_in <= 1'b0;
    t_gate();
    t_fail(16'h0064, 16'h0032, 1'b0);
    t_fail(16'h03E8, 16'h0000, 1'b1);
    t_board_fault();
    report_and_stop();
  end
endmodule // tb
